// ### rtl/serial_port.sv
// Byte serial port, master or slave, with AXI4-Lite register access.
//
// Notes on behaviour
// - Underflow bit 2 sets when transmit buffer empties; writing zero clears it.
// - Transmit-empty flag shows buffer empty; a buffer write clears it.
// - With interrupts enabled in transmit interrupt mode, transmit-empty flag setting raises the interrupt.
// - Receive-full flag sets on unread data; reading the receive buffer clears it.
// - Master transfer stops when no new byte arrives before the current byte ends.
// - MISO is input as master, output as slave.
// - MOSI is output as master, input as slave.
// - Bytes are eight bits, most significant bit first, on both lines.
// - SCLK is driven as master and received as slave.
// - Master clock rate, polarity and phase come from the two config registers.
// - Data launches on one clock edge and is sampled on the other.
// - Slave transfer starts on select low and runs until select rises, or ends after one byte when the conclusion bit is set.
// - Automatic select drives SS low for a transfer, high afterwards.
// - SS may be made an input so the port works in multimaster systems.
// - Transmit has a holding register before the shifter; receive has one after it.
// - Continuous master keeps exchanging until the buffer is empty at byte start.
// - Single-byte master asserts SS and flags empty together, sends, then releases SS.
// - Continuous master releases SS only once buffer and shifter are empty.
// - Without continuous mode a short idle gap separates bytes.
// - Transmit interrupt rises when the buffer is loaded into the shifter.
// - Master halts if the buffer is still empty at the next byte start.
// - Receive flag rises each time a byte enters the receive buffer.
// - Unread byte plus new byte sets overflow; new byte dropped unless overwrite.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "serial_port_defs.svh"

module serial_port #(
    parameter int ADDR_W = 12
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    input wire logic I_SCLK,
    output logic O_SCLK,
    output logic O_SCLK_OE,
    input wire logic I_MOSI,
    output logic O_MOSI,
    output logic O_MOSI_OE,
    input wire logic I_MISO,
    output logic O_MISO,
    output logic O_MISO_OE,
    input wire logic I_SS_N,
    output logic O_SS_N,
    output logic O_SS_N_OE,
    output logic O_IRQ
);

    localparam int IDX_W = ADDR_W - 2;

    serial_port_pkg::port_state_s r_q;
    serial_port_pkg::port_state_s r_d;
    logic tx_wr;
    logic rx_rd;
    logic do_load;
    logic do_lead;
    logic do_trail;
    logic byte_done;
    logic rx_store;
    logic master;
    logic cpol;
    logic cpha;
    logic din;
    logic [5:0] half;
    logic [5:0] gap;
    logic [IDX_W-1:0] widx;
    logic [IDX_W-1:0] ridx;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        r_d = r_q;
        tx_wr = 1'b0;
        rx_rd = 1'b0;
        do_load = 1'b0;
        do_lead = 1'b0;
        do_trail = 1'b0;
        byte_done = 1'b0;
        rx_store = 1'b0;
        master = r_q.cfg1[`C1_MASTER];
        cpol = r_q.cfg2[`C2_POLARITY];
        cpha = r_q.cfg2[`C2_PHASE];
        din = master ? r_q.miso_s : r_q.mosi_s;
        half = 6'(`HALF_BIT_BASE_CYC << r_q.cfg1[`C1_RATE_HI:`C1_RATE_LO]);
        gap = 6'(`BYTE_GAP_CYC);
        widx = r_q.aw_addr[ADDR_W-1:2];
        ridx = I_ARADDR[ADDR_W-1:2];

        // Pins from the far side are outside our clock domain.
        r_d.sclk_m = I_SCLK;
        r_d.sclk_s = r_q.sclk_m;
        r_d.sclk_p = r_q.sclk_s;
        r_d.mosi_m = I_MOSI;
        r_d.mosi_s = r_q.mosi_m;
        r_d.miso_m = I_MISO;
        r_d.miso_s = r_q.miso_m;
        r_d.ss_m = I_SS_N;
        r_d.ss_s = r_q.ss_m;
        r_d.ss_p = r_q.ss_s;

        // Write channel: address and data are caught in either order.
        if (I_AWVALID && r_q.awready) begin
            r_d.aw_hold = 1'b1;
            r_d.aw_addr = 12'(I_AWADDR);
        end
        if (I_WVALID && r_q.wready) begin
            r_d.w_hold = 1'b1;
            r_d.w_data = I_WDATA[7:0];
            r_d.w_strb = I_WSTRB[0];
        end
        if (r_q.aw_hold && r_q.w_hold && !r_q.bvalid) begin
            r_d.aw_hold = 1'b0;
            r_d.w_hold = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = `RESP_OKAY;
            if (widx == IDX_W'(`IDX_TX_BUFFER)) begin
                tx_wr = r_q.w_strb;
            end else if (widx == IDX_W'(`IDX_CONFIG_ONE)) begin
                if (r_q.w_strb) begin
                    r_d.cfg1 = r_q.w_data;
                end
            end else if (widx == IDX_W'(`IDX_CONFIG_TWO)) begin
                if (r_q.w_strb) begin
                    r_d.cfg2 = r_q.w_data;
                end
            end else if (widx == IDX_W'(`IDX_IRQ_STATUS)) begin
                if (r_q.w_strb && !r_q.w_data[`ST_TX_UNDERFLOW]) begin
                    r_d.tx_uf = 1'b0;
                end
                if (r_q.w_strb && !r_q.w_data[`ST_RX_OVERFLOW]) begin
                    r_d.rx_ovf = 1'b0;
                end
            end else if (widx != IDX_W'(`IDX_RX_BUFFER)) begin
                r_d.bresp = `RESP_SLVERR;
            end
        end else if (r_q.bvalid && I_BREADY) begin
            r_d.bvalid = 1'b0;
        end
        r_d.awready = !r_d.aw_hold;
        r_d.wready = !r_d.w_hold;

        // Read channel: one answer stands until it is taken.
        if (I_ARVALID && r_q.arready) begin
            r_d.rvalid = 1'b1;
            r_d.rresp = `RESP_OKAY;
            r_d.rdata = `RESET_WORD;
            if (ridx == IDX_W'(`IDX_RX_BUFFER)) begin
                r_d.rdata = {24'h000000, r_q.rx_buf};
                rx_rd = 1'b1;
            end else if (ridx == IDX_W'(`IDX_CONFIG_ONE)) begin
                r_d.rdata = {24'h000000, r_q.cfg1};
            end else if (ridx == IDX_W'(`IDX_CONFIG_TWO)) begin
                r_d.rdata = {24'h000000, r_q.cfg2};
            end else if (ridx == IDX_W'(`IDX_IRQ_STATUS)) begin
                r_d.rdata[`ST_TX_EMPTY] = !r_q.tx_full;
                r_d.rdata[`ST_RX_OVERFLOW] = r_q.rx_ovf;
                r_d.rdata[`ST_TX_UNDERFLOW] = r_q.tx_uf;
                r_d.rdata[`ST_RX_FULL] = r_q.rx_full;
                r_d.rdata[`ST_BUSY] = (r_q.state != serial_port_pkg::ST_IDLE);
            end else if (ridx != IDX_W'(`IDX_TX_BUFFER)) begin
                r_d.rresp = `RESP_SLVERR;
            end
        end else if (r_q.rvalid && I_RREADY) begin
            r_d.rvalid = 1'b0;
        end
        r_d.arready = !r_d.rvalid;

        // A write fills the transmit holding register.
        if (tx_wr) begin
            r_d.tx_buf = r_q.w_data;
            r_d.tx_full = 1'b1;
        end

        // ------------------------------------------------------------------
        // Transfer engine
        // ------------------------------------------------------------------
        r_d.cnt = r_q.cnt + 6'h01;
        case (r_q.state)
            serial_port_pkg::ST_IDLE: begin
                r_d.ss_n = 1'b1;
                r_d.sclk = cpol;
                r_d.cnt = 6'h00;
                r_d.edges = 4'h0;
                if (master && r_q.tx_full) begin
                    do_load = 1'b1;
                    r_d.ss_n = 1'b0;
                    r_d.state = serial_port_pkg::ST_LEAD;
                end else if (!master && !r_q.ss_s && r_q.ss_p) begin
                    do_load = 1'b1;
                    r_d.state = serial_port_pkg::ST_SLAVE;
                end
            end
            serial_port_pkg::ST_LEAD: begin
                if (r_q.cnt == half - 6'h01) begin
                    r_d.cnt = 6'h00;
                    r_d.state = serial_port_pkg::ST_SHIFT;
                end
            end
            serial_port_pkg::ST_SHIFT: begin
                if (!master) begin
                    r_d.state = serial_port_pkg::ST_IDLE;
                end else if (r_q.cnt == half - 6'h01) begin
                    r_d.cnt = 6'h00;
                    r_d.sclk = !r_q.sclk;
                    do_lead = !r_q.edges[0];
                    do_trail = r_q.edges[0];
                    r_d.edges = r_q.edges + 4'h1;
                    if (r_q.edges == `LAST_EDGE) begin
                        byte_done = 1'b1;
                        if (r_q.tx_full && r_q.cfg2[`C2_CONTINUOUS]) begin
                            do_load = 1'b1;
                        end else if (r_q.tx_full) begin
                            r_d.ss_n = 1'b1;
                            r_d.state = serial_port_pkg::ST_GAP;
                        end else begin
                            r_d.ss_n = 1'b1;
                            r_d.state = serial_port_pkg::ST_IDLE;
                        end
                    end
                end
            end
            serial_port_pkg::ST_GAP: begin
                if (r_q.cnt == gap - 6'h01) begin
                    do_load = 1'b1;
                    r_d.cnt = 6'h00;
                    r_d.ss_n = 1'b0;
                    r_d.state = serial_port_pkg::ST_LEAD;
                end
            end
            serial_port_pkg::ST_SLAVE: begin
                if (r_q.ss_s || master) begin
                    r_d.state = serial_port_pkg::ST_IDLE;
                end else if (r_q.sclk_s != r_q.sclk_p) begin
                    do_lead = (r_q.sclk_s != cpol);
                    do_trail = (r_q.sclk_s == cpol);
                    r_d.edges = r_q.edges + 4'h1;
                    if (r_q.edges == `LAST_EDGE) begin
                        byte_done = 1'b1;
                        if (r_q.cfg2[`C2_CONCLUSION]) begin
                            r_d.state = serial_port_pkg::ST_IDLE;
                        end else begin
                            do_load = 1'b1;
                        end
                    end
                end
            end
            default: begin
                r_d.state = serial_port_pkg::ST_IDLE;
            end
        endcase

        // Phase zero samples on the leading edge, phase one launches on it.
        if (do_lead) begin
            if (!cpha) begin
                r_d.rx_sh = {r_q.rx_sh[6:0], din};
            end else begin
                r_d.out = r_q.sh[7];
            end
        end
        if (do_trail) begin
            r_d.sh = {r_q.sh[6:0], 1'b0};
            if (!cpha) begin
                r_d.out = r_q.sh[6];
            end else begin
                r_d.rx_sh = {r_q.rx_sh[6:0], din};
            end
        end
        // A slave with nothing queued sends zeros and flags the underflow.
        if (do_load) begin
            r_d.sh = r_q.tx_full ? r_q.tx_buf : `RESET_BYTE;
            r_d.tx_full = tx_wr;
            if (!tx_wr) begin
                r_d.tx_uf = 1'b1;
            end
            if (!cpha) begin
                r_d.out = r_d.sh[7];
            end
        end

        // Received bytes move to the holding register.
        rx_store = byte_done;
        if (rx_store) begin
            if (r_q.rx_full && !rx_rd) begin
                r_d.rx_ovf = 1'b1;
                if (r_q.cfg1[`C1_RX_OVERWRITE]) begin
                    r_d.rx_buf = r_d.rx_sh;
                end
            end else begin
                r_d.rx_buf = r_d.rx_sh;
                r_d.rx_full = 1'b1;
            end
        end else if (rx_rd) begin
            r_d.rx_full = 1'b0;
        end

        // Pin directions follow the mode.
        r_d.sclk_oe = master;
        r_d.mosi_oe = master;
        r_d.miso_oe = !master;
        r_d.ss_oe = master && r_q.cfg1[`C1_AUTO_SS] && !r_q.cfg1[`C1_SS_INPUT];

        // The interrupt line pulses for the selected event.
        if (r_q.cfg1[`C1_TX_IRQ_MODE]) begin
            r_d.irq = r_q.cfg1[`C1_IRQ_ENABLE] && r_q.tx_full && !r_d.tx_full;
        end else begin
            r_d.irq = r_q.cfg1[`C1_IRQ_ENABLE] && rx_store;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            r_q <= '0;
            r_q.state <= serial_port_pkg::ST_IDLE;
            r_q.ss_n <= 1'b1;
            r_q.sclk_m <= 1'b1;
            r_q.sclk_s <= 1'b1;
            r_q.sclk_p <= 1'b1;
            r_q.ss_m <= 1'b1;
            r_q.ss_s <= 1'b1;
            r_q.ss_p <= 1'b1;
            r_q.miso_oe <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign O_AWREADY = r_q.awready;
    assign O_WREADY = r_q.wready;
    assign O_BRESP = r_q.bresp;
    assign O_BVALID = r_q.bvalid;
    assign O_ARREADY = r_q.arready;
    assign O_RDATA = r_q.rdata;
    assign O_RRESP = r_q.rresp;
    assign O_RVALID = r_q.rvalid;
    assign O_SCLK = r_q.sclk;
    assign O_SCLK_OE = r_q.sclk_oe;
    assign O_MOSI = r_q.out;
    assign O_MOSI_OE = r_q.mosi_oe;
    assign O_MISO = r_q.out;
    assign O_MISO_OE = r_q.miso_oe;
    assign O_SS_N = r_q.ss_n;
    assign O_SS_N_OE = r_q.ss_oe;
    assign O_IRQ = r_q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RESET_N);

    sequence s_master_end;
        byte_done && master;
    endsequence

    sequence s_gap_then_lead;
        (r_q.state == serial_port_pkg::ST_GAP) [*8] ##1 (r_q.state == serial_port_pkg::ST_LEAD);
    endsequence

    property p_uf_sticky;
        r_q.tx_uf && !(r_q.aw_hold && r_q.w_hold && !r_q.bvalid) |=> r_q.tx_uf;
    endproperty
    a_uf_sticky: assert property (p_uf_sticky) else $error("underflow flag lost");

    property p_tx_write_fills;
        tx_wr |=> r_q.tx_full;
    endproperty
    a_tx_write_fills: assert property (p_tx_write_fills) else $error("tx buffer not full");

    property p_tx_irq;
        r_q.cfg1[`C1_IRQ_ENABLE] && r_q.cfg1[`C1_TX_IRQ_MODE] && do_load && r_q.tx_full
            && !tx_wr |=> O_IRQ;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("tx interrupt missing");

    property p_rx_read_clears;
        rx_rd && !rx_store |=> !r_q.rx_full;
    endproperty
    a_rx_read_clears: assert property (p_rx_read_clears) else $error("rx full not cleared");

    property p_stop_empty;
        s_master_end and !r_q.tx_full |=> r_q.state == serial_port_pkg::ST_IDLE && O_SS_N;
    endproperty
    a_stop_empty: assert property (p_stop_empty) else $error("master did not stop");

    property p_pin_dirs;
        master && $stable(master) |=> O_MOSI_OE && O_SCLK_OE && !O_MISO_OE;
    endproperty
    a_pin_dirs: assert property (p_pin_dirs) else $error("master pin direction wrong");

    property p_ss_low_shift;
        r_q.state == serial_port_pkg::ST_SHIFT |-> !O_SS_N;
    endproperty
    a_ss_low_shift: assert property (p_ss_low_shift) else $error("select high mid byte");

    property p_continuous;
        s_master_end and r_q.tx_full && r_q.cfg2[`C2_CONTINUOUS]
            |=> r_q.state == serial_port_pkg::ST_SHIFT && !O_SS_N;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous stream broke");

    property p_gap;
        s_master_end and r_q.tx_full && !r_q.cfg2[`C2_CONTINUOUS] |=> s_gap_then_lead;
    endproperty
    a_gap: assert property (p_gap) else $error("byte gap length wrong");

    property p_overflow;
        rx_store && r_q.rx_full && !rx_rd |=> r_q.rx_ovf && r_q.rx_full;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

endmodule

// ### rtl/serial_port_defs.svh
// Register indices, field positions, reset values and timing for the serial port.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_TX_BUFFER 10'h09A
`define IDX_RX_BUFFER 10'h09B
`define IDX_CONFIG_ONE 10'h0E8
`define IDX_CONFIG_TWO 10'h0E9
`define IDX_IRQ_STATUS 10'h0EA

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define C1_RATE_LO 0
`define C1_RATE_HI 1
`define C1_AUTO_SS 2
`define C1_RX_OVERWRITE 3
`define C1_MASTER 4
`define C1_TX_IRQ_MODE 5
`define C1_SS_INPUT 6
`define C1_IRQ_ENABLE 7
`define C2_PHASE 0
`define C2_POLARITY 1
`define C2_CONCLUSION 2
`define C2_CONTINUOUS 7
`define ST_TX_EMPTY 0
`define ST_RX_OVERFLOW 1
`define ST_TX_UNDERFLOW 2
`define ST_RX_FULL 3
`define ST_BUSY 4

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define RESET_BYTE 8'h00
`define RESET_WORD 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define LAST_EDGE 4'hF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_NS 25
`define HALF_BIT_BASE_CYC 6'h04
`define BYTE_GAP_NS 200
`define BYTE_GAP_CYC ((`BYTE_GAP_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ### rtl/serial_port_pkg.sv
// Types shared by the serial port design.
package serial_port_pkg;

    // ------------------------------------------------------------------
    // Engine states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LEAD = 5'h02,
        ST_SHIFT = 5'h04,
        ST_GAP = 5'h08,
        ST_SLAVE = 5'h10
    } engine_e;

    // ------------------------------------------------------------------
    // Complete register state of the port
    // ------------------------------------------------------------------
    typedef struct packed {
        engine_e state;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] rx_buf;
        logic rx_full;
        logic rx_ovf;
        logic tx_uf;
        logic [7:0] sh;
        logic [7:0] rx_sh;
        logic out;
        logic [3:0] edges;
        logic [5:0] cnt;
        logic sclk;
        logic ss_n;
        logic sclk_oe;
        logic mosi_oe;
        logic miso_oe;
        logic ss_oe;
        logic sclk_m;
        logic sclk_s;
        logic sclk_p;
        logic mosi_m;
        logic mosi_s;
        logic miso_m;
        logic miso_s;
        logic ss_m;
        logic ss_s;
        logic ss_p;
        logic irq;
        logic aw_hold;
        logic [11:0] aw_addr;
        logic w_hold;
        logic [7:0] w_data;
        logic w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } port_state_s;

endpackage

// ### testbench/serial_peer_model.sv
// Far-side serial peer that answers a master in clock mode zero.
`timescale 1ns/10ps

module serial_peer_model (
    input wire logic i_sclk,
    input wire logic i_ss_n,
    input wire logic i_mosi,
    input wire logic [7:0] i_reply,
    output logic o_miso,
    output logic [7:0] o_got
);
    logic [7:0] sh;
    int n;
    initial begin
        o_miso = 1'b0;
        o_got = 8'h00;
        sh = 8'h00;
        n = 0;
    end
    // Selection loads the reply so bit 7 is on the line before the first edge.
    always @(negedge i_ss_n) begin
        sh = i_reply;
        n = 0;
        o_miso = i_reply[7];
    end
    always @(posedge i_sclk) begin
        if (!i_ss_n) begin
            o_got = {o_got[6:0], i_mosi};
            n++;
        end
    end
    always @(negedge i_sclk) begin
        if (!i_ss_n) begin
            if (n == 8) begin
                sh = i_reply;
                n = 0;
            end else begin
                sh = {sh[6:0], 1'b0};
            end
            o_miso = sh[7];
        end
    end
    // A released line shows the inverse, so a stale bit never passes for data.
    always @(posedge i_ss_n) o_miso = ~o_miso;
endmodule

// ### testbench/serial_port_tb.sv
// Self-checking bench for the serial port in master and slave mode.
`timescale 1ns/10ps
`include "serial_port_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module serial_port_tb;
    localparam logic [11:0] A_TX = {`IDX_TX_BUFFER, 2'b00};
    localparam logic [11:0] A_RX = {`IDX_RX_BUFFER, 2'b00};
    localparam logic [11:0] A_C1 = {`IDX_CONFIG_ONE, 2'b00};
    localparam logic [11:0] A_C2 = {`IDX_CONFIG_TWO, 2'b00};
    localparam logic [11:0] A_ST = {`IDX_IRQ_STATUS, 2'b00};
    logic clk = 1'b0, rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [1:0] bresp, rresp, resp;
    logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, irq, peer_miso;
    logic [7:0] reply = 8'h00, got, rd;
    logic awready, wready, bvalid, arready, rvalid;
    // The bench plays the far master while the port is a slave.
    logic m_sclk = 1'b0, m_mosi = 1'b0, m_ss_n = 1'b1;
    logic [7:0] s_got = 8'h00;
    wire sclk_w = sclk_oe ? sclk_o : m_sclk;
    wire mosi_w = mosi_oe ? mosi_o : m_mosi;
    wire miso_w = miso_oe ? miso_o : peer_miso;
    wire ss_w = ss_oe ? ss_o : m_ss_n;
    int num_errors = 0, checked = 0, cycles = 0, ss_rises = 0, irqs = 0;

    serial_port i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .I_SCLK(sclk_w), .O_SCLK(sclk_o), .O_SCLK_OE(sclk_oe), .I_MOSI(mosi_w),
        .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe), .I_MISO(miso_w), .O_MISO(miso_o),
        .O_MISO_OE(miso_oe), .I_SS_N(ss_w), .O_SS_N(ss_o), .O_SS_N_OE(ss_oe), .O_IRQ(irq));

    serial_peer_model i_peer (.i_sclk(sclk_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
        .i_reply(reply), .o_miso(peer_miso), .o_got(got));

    always #12.5 clk = ~clk;
    always @(posedge ss_w) ss_rises++;
    always @(posedge clk) begin
        if (irq === 1'b1) irqs++;
        cycles++;
        // The whole sequence needs well under a tenth of this ceiling.
        if (cycles == 40000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic send_wait(input logic [7:0] d);
        wr(A_TX, d);
        repeat (2) @(posedge clk);
        do rdr(A_ST); while (rd[`ST_BUSY] !== 1'b0);
    endtask

    // One mode-zero byte as far master: 200 ns clock, data set mid low phase.
    task automatic slave_byte(input logic [7:0] d);
        @(posedge clk);
        m_ss_n <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            repeat (2) @(posedge clk);
            m_mosi <= d[i];
            repeat (2) @(posedge clk);
            m_sclk <= 1'b1;
            s_got = {s_got[6:0], miso_w};
            repeat (4) @(posedge clk);
            m_sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        m_ss_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rdr(A_C1); `CHK(rd, 8'h00)
        rdr(A_C2); `CHK(rd, 8'h00)
        rdr(A_ST); `CHK(rd, 8'h01)
        `CHK({ss_o, ss_oe}, 2'b10)
        rdr(12'h000); `CHK(resp, `RESP_SLVERR)
        wr(12'h004, 8'h00); `CHK(resp, `RESP_SLVERR)
        wr(A_C1, 8'hB4); `CHK(resp, `RESP_OKAY)
        rdr(A_C1); `CHK(rd, 8'hB4)
        `CHK({mosi_oe, miso_oe, sclk_oe}, 3'b101)
        reply = 8'h3C;
        send_wait(8'hA5);
        `CHK(got, 8'hA5)
        `CHK(ss_w, 1'b1)
        `CHK(irqs, 1)
        `CHK(rd, 8'h0D)
        rdr(A_RX); `CHK(rd, 8'h3C)
        rdr(A_ST); `CHK(rd, 8'h05)
        wr(A_ST, 8'h00);
        rdr(A_ST); `CHK(rd, 8'h01)
        reply = 8'h11;
        send_wait(8'h5A);
        reply = 8'h22;
        send_wait(8'h66);
        `CHK(rd, 8'h0F)
        rdr(A_RX); `CHK(rd, 8'h11)
        wr(A_ST, 8'h00);
        wr(A_C2, 8'h80);
        ss_rises = 0;
        irqs = 0;
        wr(A_TX, 8'h81);
        send_wait(8'h42);
        `CHK(ss_rises, 1)
        `CHK(got, 8'h42)
        `CHK(irqs, 2)
        wr(A_C2, 8'h00);
        ss_rises = 0;
        wr(A_TX, 8'h18);
        send_wait(8'hE7);
        `CHK(ss_rises, 2)
        `CHK(got, 8'hE7)
        wr(A_C1, 8'h88);
        wr(A_TX, 8'hC3);
        irqs = 0;
        slave_byte(8'h96);
        `CHK({sclk_oe, mosi_oe, miso_oe}, 3'b001)
        `CHK(s_got, 8'hC3)
        `CHK(irqs, 1)
        rdr(A_RX); `CHK(rd, 8'h96)
        complete_run();
    end
endmodule
